// file: verilog/evr_pkg.sv
package evr_pkg;
    // Sizes
    localparam int NCH = 8;
    localparam int NUSER = 16;
    localparam int NGEN = 64;
    localparam int CH_W = 3;
    localparam int U_W = 4;
    localparam int GSEL_W = 6;
    // Register byte addresses
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CHCFG = 8'h04;
    localparam logic [7:0] OFS_USER = 8'h08;
    localparam logic [7:0] OFS_STATE = 8'h0C;
    localparam logic [7:0] OFS_IECLR = 8'h10;
    localparam logic [7:0] OFS_IESET = 8'h14;
    localparam logic [7:0] OFS_FLAGS = 8'h18;
    // Field positions
    localparam int SRST_BIT = 0;
    localparam int POLICY_BIT = 4;
    localparam int SOFT_EVENT_TRIGGER_BIT = 8;
    localparam int GEN_LSB = 16;
    localparam int PATH_LSB = 24;
    localparam int EDGE_LSB = 26;
    localparam int UCH_LSB = 8;
    // Field limits
    localparam logic [7:0] CH_IDX_MAX = 8'h07;
    localparam logic [7:0] UCH_NONE = 8'h00;
    localparam logic [7:0] UCH_MAX = 8'h08;
    localparam logic [7:0] UCH_ONE = 8'h01;
    localparam logic [7:0] NO_GEN = 8'h00;
    localparam logic [7:0] GEN_LIMIT = 8'h40;
    localparam logic [7:0] USER_LIMIT = 8'h10;
    localparam logic [NCH-1:0] CH_ONE = 8'h01;
    // Generators allowed on the asynchronous path
    localparam logic [NGEN-1:0] ASYNC_OK = 64'hFFFF_FFFF_FFFF_FFFE;
    // Path and edge encodings
    typedef enum logic [1:0] {
        PATH_SYNC = 2'h0,
        PATH_RESYNC = 2'h1,
        PATH_ASYNC = 2'h2,
        PATH_RSVD = 2'h3
    } evr_path_t;
    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } evr_edge_t;
    // Stored settings of one channel
    typedef struct packed {
        logic [7:0] gen;
        evr_path_t path;
        evr_edge_t edg;
    } evr_cfg_t;
    localparam evr_cfg_t CFG_RST = '{gen: 8'h00, path: PATH_SYNC, edg: EDGE_NONE};
    // APB request from the master
    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } evr_apb_req_t;
endpackage

// file: verilog/evr_regs.sv
`timescale 1ns/1ps
module evr_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire evr_pkg::evr_apb_req_t apb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Unit state and event sources
    input wire logic unit_enabled,
    input wire logic [evr_pkg::NGEN-1:0] gen_level,
    input wire logic [evr_pkg::NUSER-1:0] user_ready,
    // Channel and user side
    output logic [evr_pkg::NCH-1:0] chan_out,
    output logic [evr_pkg::NCH-1:0] gclk_req,
    output logic [evr_pkg::NUSER-1:0] user_event,
    output logic irq
);
    import evr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic gen_pick(input logic [7:0] g, input logic [NGEN-1:0] v);
        gen_pick = (g != NO_GEN) && (g < GEN_LIMIT) ? v[g[GSEL_W-1:0]] : 1'b0;
    endfunction

    function automatic logic [CH_W-1:0] ch_of(input logic [7:0] v);
        logic [7:0] d;
        d = v - UCH_ONE;
        ch_of = d[CH_W-1:0];
    endfunction

    function automatic logic uch_valid(input logic [7:0] v);
        uch_valid = (v != UCH_NONE) && (v <= UCH_MAX);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    logic policy_r;
    logic [7:0] chan_idx_r;
    logic [7:0] user_sel_r;
    evr_cfg_t cfg_r [NCH];
    logic [7:0] user_ch_r [NUSER];
    logic [NCH-1:0] prev_r;
    logic [NCH-1:0] ev_r;
    logic [NCH-1:0] pending_r;
    logic [15:0] en_r;
    logic [15:0] flags_r;
    logic [31:0] prdata_r;
    logic [NGEN-1:0] gs1_r;
    logic [NGEN-1:0] gs2_r;
    logic [NGEN-1:0] gs3_r;
    logic [NGEN-1:0] gfilt_r;
    logic [NCH-1:0] fire;
    logic [NCH-1:0] ovr_set;
    logic [NCH-1:0] evd_set;
    logic [NCH-1:0] users_ok;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire acc = apb.psel & apb.penable;
    wire wr = acc & apb.pwrite;
    wire setup_rd = apb.psel & ~apb.penable & ~apb.pwrite;
    wire [31:0] wd = apb.pwdata & lane_mask(apb.pstrb);
    wire hit_ctrl = apb.paddr == OFS_CTRL;
    wire hit_cfg = apb.paddr == OFS_CHCFG;
    wire hit_user = apb.paddr == OFS_USER;
    wire hit_state = apb.paddr == OFS_STATE;
    wire hit_ieclr = apb.paddr == OFS_IECLR;
    wire hit_ieset = apb.paddr == OFS_IESET;
    wire hit_flags = apb.paddr == OFS_FLAGS;
    wire mapped = hit_ctrl | hit_cfg | hit_user | hit_state | hit_ieclr | hit_ieset | hit_flags;
    wire wr_ctrl = wr & hit_ctrl & apb.pstrb[0];
    wire srst = wr_ctrl & apb.pwdata[SRST_BIT];
    wire wr_cfg = wr & hit_cfg;
    wire wr_usr = wr & hit_user & ~unit_enabled;

    // Zero wait states, error on unmapped address
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata = prdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Channel register write decode
    wire [7:0] idx_new = apb.pstrb[0] ? apb.pwdata[7:0] : chan_idx_r;
    wire idx_ok = idx_new <= CH_IDX_MAX;
    wire cfg_open = wr_cfg & idx_ok & ~unit_enabled;
    evr_cfg_t cur_cfg;
    evr_cfg_t new_cfg;
    wire [7:0] gen_new = apb.pstrb[2] ? apb.pwdata[GEN_LSB +: 8] : cur_cfg.gen;
    wire evr_path_t path_in = evr_path_t'(apb.pwdata[PATH_LSB +: 2]);
    wire path_rsvd = path_in == PATH_RSVD;
    wire path_bar = (path_in == PATH_ASYNC) & ~ASYNC_OK[gen_new[GSEL_W-1:0]];
    wire path_take = apb.pstrb[3] & ~path_rsvd & ~path_bar;
    wire sw_hit = wr_cfg & idx_ok & (&apb.pstrb[1:0]) & apb.pwdata[SOFT_EVENT_TRIGGER_BIT];
    wire [NCH-1:0] sw_fire = sw_hit ? CH_ONE << idx_new[CH_W-1:0] : '0;

    // Merge written fields over the indexed channel's settings
    assign cur_cfg = cfg_r[idx_new[CH_W-1:0]];
    assign new_cfg = '{gen: gen_new,
                       path: path_take ? path_in : cur_cfg.path,
                       edg: apb.pstrb[3] ? evr_edge_t'(apb.pwdata[EDGE_LSB +: 2]) : cur_cfg.edg};

    // User register write decode
    wire [7:0] usel_new = apb.pstrb[0] ? apb.pwdata[7:0] : user_sel_r;
    wire [7:0] uch_new = apb.pwdata[UCH_LSB +: 8];
    wire uch_take = wr_usr & apb.pstrb[1] & (uch_new <= UCH_MAX);

    ////////////////////////////////////////////////////////////////////////
    // Control, index and selector registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            policy_r <= 1'b0;
            chan_idx_r <= 8'h00;
            user_sel_r <= 8'h00;
        end else if (srst) begin
            policy_r <= 1'b0;
            chan_idx_r <= 8'h00;
            user_sel_r <= 8'h00;
        end else begin
            if (wr_ctrl)
                policy_r <= apb.pwdata[POLICY_BIT];
            if (wr_cfg & apb.pstrb[0])
                chan_idx_r <= apb.pwdata[7:0];
            if (wr_usr & apb.pstrb[0])
                user_sel_r <= apb.pwdata[7:0];
        end
    end

    // Generator levels: three-stage capture, change taken when the last two stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gs1_r <= '0;
            gs2_r <= '0;
            gs3_r <= '0;
            gfilt_r <= '0;
        end else begin
            gs1_r <= gen_level;
            gs2_r <= gs1_r;
            gs3_r <= gs2_r;
            gfilt_r <= (gs2_r & gs3_r) | (gfilt_r & (gs2_r ^ gs3_r));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Readiness of all users per channel
    always_comb begin
        users_ok = '1;
        for (int u = 0; u < NUSER; u++) begin
            if (uch_valid(user_ch_r[u]) && !user_ready[u])
                users_ok[ch_of(user_ch_r[u])] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channels
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            wire is_async = cfg_r[c].path == PATH_ASYNC;
            wire is_resync = cfg_r[c].path == PATH_RESYNC;
            wire lvl_raw = gen_pick(cfg_r[c].gen, gen_level);
            wire lvl = is_resync ? gen_pick(cfg_r[c].gen, gfilt_r) : lvl_raw;
            wire rise = lvl & ~prev_r[c];
            wire fall = ~lvl & prev_r[c];
            wire on_rise = (cfg_r[c].edg == EDGE_RISE) | (cfg_r[c].edg == EDGE_BOTH);
            wire on_fall = (cfg_r[c].edg == EDGE_FALL) | (cfg_r[c].edg == EDGE_BOTH);
            wire det = (on_rise & rise) | (on_fall & fall);

            // Edge logic is bypassed on the asynchronous path
            assign fire[c] = ~is_async & (det | sw_fire[c]);
            assign ovr_set[c] = fire[c] & is_resync & (pending_r[c] | ~users_ok[c]);
            assign evd_set[c] = fire[c] & is_resync;
            assign chan_out[c] = is_async ? lvl_raw : ev_r[c];
            assign gclk_req[c] = ~is_async & (policy_r | fire[c] | ev_r[c] | pending_r[c]);

            // Settings, edge history, event pulse and pending state
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_r[c] <= CFG_RST;
                    prev_r[c] <= 1'b0;
                    ev_r[c] <= 1'b0;
                    pending_r[c] <= 1'b0;
                end else if (srst) begin
                    cfg_r[c] <= CFG_RST;
                    prev_r[c] <= 1'b0;
                    ev_r[c] <= 1'b0;
                    pending_r[c] <= 1'b0;
                end else begin
                    if (cfg_open && idx_new[CH_W-1:0] == c)
                        cfg_r[c] <= new_cfg;
                    prev_r[c] <= lvl;
                    ev_r[c] <= fire[c];
                    pending_r[c] <= fire[c] | (pending_r[c] & ~users_ok[c]);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // User multiplexers
    genvar u;
    generate
        for (u = 0; u < NUSER; u++) begin : g_user
            assign user_event[u] = uch_valid(user_ch_r[u]) & chan_out[ch_of(user_ch_r[u])];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    user_ch_r[u] <= UCH_NONE;
                else if (srst)
                    user_ch_r[u] <= UCH_NONE;
                else if (uch_take && usel_new == u)
                    user_ch_r[u] <= uch_new;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Interrupt enables and flags; a new event beats a clear
    wire [15:0] ie_set = (wr & hit_ieset) ? wd[15:0] : 16'h0000;
    wire [15:0] ie_clr = (wr & hit_ieclr) ? wd[15:0] : 16'h0000;
    wire [15:0] fl_clr = (wr & hit_flags) ? wd[15:0] : 16'h0000;
    wire [15:0] fl_set = {evd_set, ovr_set};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 16'h0000;
            flags_r <= 16'h0000;
        end else if (srst) begin
            en_r <= 16'h0000;
            flags_r <= 16'h0000;
        end else begin
            en_r <= (en_r | ie_set) & ~ie_clr;
            flags_r <= (flags_r & ~fl_clr) | fl_set;
        end
    end

    assign irq = |(flags_r & en_r);

    ////////////////////////////////////////////////////////////////////////
    // Read data, sampled in the setup phase
    wire sel_ok = chan_idx_r <= CH_IDX_MAX;
    wire evr_cfg_t rd_cfg = sel_ok ? cfg_r[chan_idx_r[CH_W-1:0]] : CFG_RST;
    wire usel_ok = user_sel_r < USER_LIMIT;
    wire [7:0] rd_uch = usel_ok ? user_ch_r[user_sel_r[U_W-1:0]] : UCH_NONE;
    wire [31:0] rd_ctrl = {27'h0, policy_r, 4'h0};
    wire [31:0] rd_cfg_w = {4'h0, rd_cfg.edg, rd_cfg.path, rd_cfg.gen, 8'h00, chan_idx_r};
    wire [31:0] rd_state = {16'h0, pending_r, users_ok};
    wire [31:0] rmux = hit_ctrl ? rd_ctrl :
                       hit_cfg ? rd_cfg_w :
                       hit_user ? {16'h0, rd_uch, user_sel_r} :
                       hit_state ? rd_state :
                       (hit_ieclr | hit_ieset) ? {16'h0, en_r} :
                       hit_flags ? {16'h0, flags_r} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata_r <= 32'h0;
        else if (setup_rd)
            prdata_r <= rmux;
    end
endmodule

// file: verification/evr_regs_assertions.sv
`timescale 1ns/1ps
module evr_regs_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus side
    input wire evr_pkg::evr_apb_req_t apb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Event side
    input wire logic unit_enabled,
    input wire logic [evr_pkg::NGEN-1:0] gen_level,
    input wire logic [evr_pkg::NUSER-1:0] user_ready,
    input wire logic [evr_pkg::NCH-1:0] chan_out,
    input wire logic [evr_pkg::NCH-1:0] gclk_req,
    input wire logic [evr_pkg::NUSER-1:0] user_event,
    input wire logic irq
);
    import evr_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Decoded bus phases
    wire logic acc = apb.psel && apb.penable;
    wire logic wr = acc && apb.pwrite;
    wire logic mapped = apb.paddr[1:0] == 2'h0 && apb.paddr <= OFS_FLAGS;
    wire logic srst = wr && apb.paddr == OFS_CTRL && apb.pstrb[0] && apb.pwdata[SRST_BIT];
    wire logic clr_wr = wr && (apb.paddr == OFS_IECLR || apb.paddr == OFS_FLAGS || srst);
    ////////////////////////////////////////////////////////////////
    ready_always_a: assert property (pready)
        else $error("pready low");
    err_unmapped_a: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    err_idle_a: assert property (!acc |-> !pslverr)
        else $error("pslverr outside access");
    srst_clear_a: assert property (srst |=> gclk_req == '0 && !irq && chan_out == '0)
        else $error("soft reset left state");
    cfg_read_a: assert property (acc && !apb.pwrite && apb.paddr == OFS_CHCFG
        |-> prdata[15:8] == 8'h00 && prdata[31:28] == 4'h0) else $error("config read bits");
    user_route_a: assert property (|user_event |-> |chan_out)
        else $error("user event without channel");
    irq_rise_a: assert property ($rose(irq) |-> (|chan_out)
        || $past(wr && apb.paddr == OFS_IESET)) else $error("irq rose without cause");
    irq_fall_a: assert property ($fell(irq) |-> $past(clr_wr))
        else $error("irq fell without clear");
    cover property (srst);
    cover property ($rose(irq));
    cover property (|user_event);
endmodule
bind evr_regs evr_regs_chk u_chk (.pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .unit_enabled(unit_enabled), .gen_level(gen_level),
    .user_ready(user_ready), .chan_out(chan_out), .gclk_req(gclk_req),
    .user_event(user_event), .irq(irq));

// file: verification/evr_far_model.sv
`timescale 1ns/1ps
module evr_far_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Test controls
    input wire logic flip,
    input wire logic [evr_pkg::GSEL_W-1:0] flip_idx,
    input wire logic slow,
    // Generators and users
    output logic [evr_pkg::NGEN-1:0] gen_level,
    output logic [evr_pkg::NUSER-1:0] user_ready
);
    import evr_pkg::*;
    logic [NGEN-1:0] lvl_r;
    logic [NUSER-1:0] busy_r;
    // Levels move only on command, so generators stay quiet around resets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_r <= '0;
            busy_r <= '0;
        end else begin
            if (flip) lvl_r[flip_idx] <= ~lvl_r[flip_idx];
            busy_r <= {busy_r[NUSER-2:0], ~busy_r[NUSER-1]};
        end
    end
    // Generator 0 means no source; slow users show a moving pattern
    assign gen_level = {lvl_r[NGEN-1:1], 1'b0};
    assign user_ready = slow ? busy_r : '1;
endmodule

// file: verification/event_channel_config_regs_tb.sv
`timescale 1ns/1ps
module event_channel_config_regs_tb;
    import evr_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    evr_apb_req_t apb = '0;
    logic unit_enabled = 0;
    logic flip = 0;
    logic [GSEL_W-1:0] flip_idx = 6'h05;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, irq;
    wire logic [NGEN-1:0] gen_level;
    wire logic [NUSER-1:0] user_ready, user_event;
    wire logic [NCH-1:0] chan_out, gclk_req;
    int miscompares = 0, tests_run = 0, cycles = 0, pulses = 0, seed = 16142;
    logic [32:0] exp_q[$];
    logic [7:0] g;
    always #4 pclk = ~pclk;
    evr_regs uut (.pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .unit_enabled(unit_enabled), .gen_level(gen_level),
        .user_ready(user_ready), .chan_out(chan_out), .gclk_req(gclk_req),
        .user_event(user_event), .irq(irq));
    evr_far_model far (.pclk(pclk), .presetn(presetn), .flip(flip), .flip_idx(flip_idx),
        .slow(1'b0), .gen_level(gen_level), .user_ready(user_ready));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One APB transfer; the watcher pops a read's expectation in its access phase
    task automatic xfer(input logic [7:0] a, input logic w, input logic [3:0] s,
        input logic [31:0] d);
        @(posedge pclk);
        apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d, pstrb: s};
        @(posedge pclk);
        apb.penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        xfer(a, 1'b1, s, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back({1'b0, e});
        xfer(a, 1'b0, 4'h0, 32'h0);
    endtask
    task automatic flip_gen();
        @(posedge pclk) flip <= 1'b1;
        @(posedge pclk) flip <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask
    // Watcher: read results against oldest note, pulses counted
    always @(posedge pclk) begin
        if (apb.psel && apb.penable && !apb.pwrite && pready)
            chk({pslverr, prdata}, exp_q.pop_front());
        if (chan_out[0] === 1'b1) begin
            pulses++;
            chk(33'(user_event[0]), 33'h1);
        end
    end
    // Hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) if (i != 3) rd(8'(4 * i), 32'h0);
        // Channel 0 resynchronized from generator 5, routed to user 0
        wr(OFS_CHCFG, 4'hF, 32'h0505_0000);
        wr(OFS_USER, 4'h3, 32'h0000_0100);
        wr(OFS_IESET, 4'h3, 32'h0000_0100);
        for (int e = 0; e < 4; e++) begin
            wr(OFS_CHCFG, 4'h8, {4'h0, 2'(e), 2'h1, 24'h0});
            flip_gen();
            flip_gen();
        end
        chk(33'(pulses), 33'h4);
        chk(33'(irq), 33'h1);
        rd(OFS_FLAGS, 32'h0000_0100);
        wr(OFS_FLAGS, 4'h3, 32'h0000_0100);
        @(negedge pclk);
        chk(33'(irq), 33'h0);
        wr(OFS_CHCFG, 4'h3, 32'h0000_0100);
        repeat (3) @(posedge pclk);
        chk(33'(pulses), 33'h5);
        rd(OFS_IECLR, 32'h0000_0100);
        wr(OFS_IECLR, 4'h3, 32'h0000_0100);
        rd(OFS_IESET, 32'h0);
        // Soft reset beats the policy bit of the same write
        wr(OFS_CTRL, 4'h1, 32'h11);
        rd(OFS_CHCFG, 32'h0);
        rd(OFS_USER, 32'h0);
        rd(OFS_CTRL, 32'h0);
        rd(OFS_STATE, 32'h0000_00FF);
        wr(OFS_CTRL, 4'h1, 32'h10);
        @(negedge pclk);
        chk(33'(gclk_req), 33'hFF);
        g = 8'($unsigned($random(seed)) % 63 + 1);
        wr(OFS_CHCFG, 4'hF, {6'h0, 2'h2, g, 16'h0002});
        @(negedge pclk);
        chk(33'(gclk_req), 33'hFB);
        wr(OFS_CHCFG, 4'h8, 32'h0300_0000);
        unit_enabled <= 1'b1;
        wr(OFS_CHCFG, 4'h4, 32'h0007_0000);
        rd(OFS_CHCFG, {6'h0, 2'h2, g, 16'h0002});
        unit_enabled <= 1'b0;
        wr(OFS_CHCFG, 4'h1, 32'h08);
        rd(OFS_CHCFG, 32'h08);
        wr(8'h1C, 4'hF, 32'hFFFF_FFFF);
        // Unmapped read answers with an error and zero data
        exp_q.push_back({1'b1, 32'h0});
        xfer(8'h1C, 1'b0, 4'h0, 32'h0);
        repeat (2) @(posedge pclk);
        stop_test();
    end
endmodule
